// file: rtl/srs_consts.svh
// Constants for the sleep, reset and start-up sequencer.
// Assumes inclusion by the sequencer module and the testbench only.
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_CLK_PERIOD_NS 40
`define SRS_RST_MIN_NS 50
`define SRS_RST_CYC ((`SRS_RST_MIN_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_WAKE_HOLD_CYC 4
`define SRS_LEVEL_WD_CYC 2
`define SRS_CK_1K 17'h00400
`define SRS_CK_16K 17'h04000
`define SRS_CK_32K 17'h08000
`define SRS_CK_6 17'h00006
`define SRS_WD_1K 17'h00400
`define SRS_WD_16K 17'h04000
`define SRS_CLOCK_SELECT_CODE_RESET 4'h2
`define SRS_REG_CTRL 32'h00000000
`define SRS_REG_CFG 32'h00000004
`define SRS_REG_STAT 32'h00000008
`define SRS_BIT_SE 5
`define SRS_BIT_SM 4
`define SRS_BIT_WATCHDOG_RESET_FLAG 3
`define SRS_BIT_PIN_RESET_FLAG 1
`define SRS_BIT_POWERUP_RESET_FLAG 0
`define SRS_RESP_OKAY 2'h0
`define SRS_RESP_SLVERR 2'h2
`endif

// file: rtl/srs_pkg.sv
// Types for the sleep, reset and start-up sequencer.
// Assumes the constants header lies beside it.
package srs_pkg;
	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_RT = 6'h02,
		ST_CK = 6'h04,
		ST_RUN = 6'h08,
		ST_SLEEP = 6'h10,
		ST_WAKE = 6'h20
	} srs_state_type;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} srs_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} srs_axi_rsp_type;

	typedef struct packed {
		srs_state_type st;
		logic [16:0] cnt;
		logic [1:0] wd_seen;
		logic [2:0] rst_s;
		logic [2:0] lvl_s;
		logic [2:0] wdo_s;
		logic [2:0] wdt_s;
		logic wdt_q;
		logic [1:0] rst_low;
		logic [2:0] hold;
		logic pdown;
		logic lvl_ok;
		logic se;
		logic sm;
		logic watchdog_reset_flag;
		logic pin_reset_flag;
		logic powerup_reset_flag;
		logic [3:0] clock_select_code;
		logic core_rst;
		logic core_halt;
		logic osc_en;
		logic irq_wake;
		logic aw_done;
		logic w_done;
		logic [31:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		srs_axi_rsp_type axi;
	} srs_state_all_type;
endpackage

// file: rtl/srs_sequencer.sv
// Sleep entry, wake-up, reset source tracking and start-up delay sequencer.
// Assumes a core that pulses sleep_instr, a watchdog oscillator tick and an AXI4-Lite master.
`timescale 1ns/1ps
`include "srs_consts.svh"

// Overview of operation
// - Sleep happens only on sleep instruction with sleep enable bit set.
// - Idle sleep halts only the core; any enabled interrupt or watchdog wakes.
// - Power-down sleep stops the main oscillator; level inputs and watchdog stay.
// - Power-down wakes only on supply reset, pin reset, watchdog reset, or level wake.
// - Interrupt wake holds the core four cycles, then resumes with state kept.
// - Any reset during sleep wakes the device into the reset vector.
// - Level wake needs two watchdog cycles, or the wake period if shorter.
// - Level lost before wake period ends: wake but skip the interrupt.
// - Leaving power-down waits only the clock-count part of start-up.
// - Reset pin low beyond 50 ns resets; shorter pulses may be ignored (code resets only after three synchronised low cycles, 120 ns).
// - Any reset clears sleep enable and mode bits and restarts execution from address zero; clock-select code is kept.
// - Start-up delay follows clock-select code: clock count plus optional real time.
// - Real-time part counts 1K or 16K watchdog oscillator cycles.
// - Clock-select code resets to internal RC with 67 ms plus 6 clocks.
// - After power-on release a delay counter holds reset for the time-out.
// - Supply below detection level reasserts reset at once, no counting.
// - After reset pin rises, the full time-out runs before core start.
// - Watchdog time-out resets for as long as it stays high once synchronised; time-out starts on its fall.
// - Sleep enable is bit 5, sleep mode select bit 4 of control register.
// - Each reset source sets its own flag; write zero clears; power-on clears others.
module srs_sequencer (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire srs_pkg::srs_axi_req_type axi_req,
	output srs_pkg::srs_axi_rsp_type axi_rsp,
	// Supply, pin and watchdog sources
	input wire logic supply_ok,
	input wire logic reset_pin_n,
	input wire logic wd_osc,
	input wire logic wd_timeout,
	// Core side
	input wire logic sleep_instr,
	input wire logic irq_pending,
	input wire logic level_wake_n,
	output logic core_reset,
	output logic core_halt,
	output logic osc_enable,
	output logic wake_irq
);
	import srs_pkg::*;

	srs_state_all_type s_r, s_nxt;

	function automatic logic [16:0] ck_part(input logic [3:0] code);
		case (code)
			4'hf, 4'he, 4'hd, 4'h9: ck_part = `SRS_CK_1K;
			4'hc, 4'hb, 4'ha: ck_part = `SRS_CK_16K;
			4'h8: ck_part = `SRS_CK_32K;
			default: ck_part = `SRS_CK_6;
		endcase
	endfunction

	function automatic logic [16:0] rt_part(input logic [3:0] code);
		case (code)
			4'he, 4'hb, 4'h6, 4'h3, 4'h0: rt_part = `SRS_WD_1K;
			4'hd, 4'ha, 4'h9, 4'h8, 4'h5, 4'h2: rt_part = `SRS_WD_16K;
			default: rt_part = 17'h00000;
		endcase
	endfunction

	logic rst_low_now, wd_tick, wdt_fall, any_rst, lvl_active;

	always_comb begin
		s_nxt = s_r;
		// Three-stage synchronisers; for pin, level and time-out the second and third must agree
		s_nxt.rst_s = {s_r.rst_s[1:0], reset_pin_n};
		s_nxt.lvl_s = {s_r.lvl_s[1:0], level_wake_n};
		s_nxt.wdo_s = {s_r.wdo_s[1:0], wd_osc};
		s_nxt.wdt_s = {s_r.wdt_s[1:0], wd_timeout};
		rst_low_now = (s_r.rst_s[2:1] == 2'b00);
		lvl_active = (s_r.lvl_s[2:1] == 2'b00);
		wd_tick = (s_r.wdo_s[2:1] == 2'b11) && !s_r.wdo_s[2] ? 1'b0 :
			(s_r.wdo_s[1] && !s_r.wdo_s[2]);
		// Time-out seen high, held until the synchronised level agrees low
		s_nxt.wdt_q = (s_r.wdt_s[2:1] == 2'b11) || (s_r.wdt_q && s_r.wdt_s[2:1] != 2'b00);
		wdt_fall = s_r.wdt_q && (s_r.wdt_s[2:1] == 2'b00);
		// Pin filter: low must persist beyond the minimum width
		if (rst_low_now && s_r.rst_low != 2'(`SRS_RST_CYC))
			s_nxt.rst_low = s_r.rst_low + 2'h1;
		else if (!rst_low_now)
			s_nxt.rst_low = 2'h0;
		any_rst = 1'b0;
		s_nxt.irq_wake = 1'b0;
		// Bus slave
		s_nxt.axi.bvalid = s_r.axi.bvalid && !axi_req.bready;
		s_nxt.axi.rvalid = s_r.axi.rvalid && !axi_req.rready;
		s_nxt.axi.awready = !s_r.aw_done && !s_r.axi.bvalid;
		s_nxt.axi.wready = !s_r.w_done && !s_r.axi.bvalid;
		s_nxt.axi.arready = !s_r.axi.rvalid && !s_r.axi.arready;
		if (axi_req.awvalid && s_r.axi.awready) begin
			s_nxt.aw_done = 1'b1;
			s_nxt.aw_addr = axi_req.awaddr;
			s_nxt.axi.awready = 1'b0;
		end
		if (axi_req.wvalid && s_r.axi.wready) begin
			s_nxt.w_done = 1'b1;
			s_nxt.w_data = axi_req.wdata;
			s_nxt.w_strb = axi_req.wstrb;
			s_nxt.axi.wready = 1'b0;
		end
		if (s_r.aw_done && s_r.w_done) begin
			s_nxt.aw_done = 1'b0;
			s_nxt.w_done = 1'b0;
			s_nxt.axi.bvalid = 1'b1;
			s_nxt.axi.bresp = `SRS_RESP_OKAY;
			if (s_r.aw_addr == `SRS_REG_CTRL) begin
				if (s_r.w_strb[0]) begin
					s_nxt.se = s_r.w_data[`SRS_BIT_SE];
					s_nxt.sm = s_r.w_data[`SRS_BIT_SM];
					// Writing zero clears a flag; set wins below
					s_nxt.watchdog_reset_flag = s_r.watchdog_reset_flag & s_r.w_data[`SRS_BIT_WATCHDOG_RESET_FLAG];
					s_nxt.pin_reset_flag = s_r.pin_reset_flag & s_r.w_data[`SRS_BIT_PIN_RESET_FLAG];
					s_nxt.powerup_reset_flag = s_r.powerup_reset_flag & s_r.w_data[`SRS_BIT_POWERUP_RESET_FLAG];
				end
			end else if (s_r.aw_addr == `SRS_REG_CFG) begin
				if (s_r.w_strb[0])
					s_nxt.clock_select_code = s_r.w_data[3:0];
			end else if (s_r.aw_addr != `SRS_REG_STAT) begin
				s_nxt.axi.bresp = `SRS_RESP_SLVERR;
			end
		end
		if (axi_req.arvalid && s_r.axi.arready) begin
			s_nxt.axi.arready = 1'b0;
			s_nxt.axi.rvalid = 1'b1;
			s_nxt.axi.rresp = `SRS_RESP_OKAY;
			s_nxt.axi.rdata = 32'h00000000;
			case (axi_req.araddr)
				`SRS_REG_CTRL: begin
					s_nxt.axi.rdata[`SRS_BIT_SE] = s_r.se;
					s_nxt.axi.rdata[`SRS_BIT_SM] = s_r.sm;
					s_nxt.axi.rdata[`SRS_BIT_WATCHDOG_RESET_FLAG] = s_r.watchdog_reset_flag;
					s_nxt.axi.rdata[`SRS_BIT_PIN_RESET_FLAG] = s_r.pin_reset_flag;
					s_nxt.axi.rdata[`SRS_BIT_POWERUP_RESET_FLAG] = s_r.powerup_reset_flag;
				end
				`SRS_REG_CFG: s_nxt.axi.rdata[3:0] = s_r.clock_select_code;
				`SRS_REG_STAT: s_nxt.axi.rdata[5:0] = s_r.st;
				default: s_nxt.axi.rresp = `SRS_RESP_SLVERR;
			endcase
		end
		// Reset sources, highest priority
		if (!supply_ok) begin
			// Immediate, no counting while supply is low
			s_nxt.powerup_reset_flag = 1'b1;
			s_nxt.watchdog_reset_flag = 1'b0;
			s_nxt.pin_reset_flag = 1'b0;
			any_rst = 1'b1;
		end else if (rst_low_now && s_r.rst_low == 2'(`SRS_RST_CYC)) begin
			s_nxt.pin_reset_flag = 1'b1;
			any_rst = 1'b1;
		end else if (s_nxt.wdt_q) begin
			s_nxt.watchdog_reset_flag = 1'b1;
			any_rst = 1'b1;
		end
		if (any_rst) begin
			// Sleep enable and mode bits return to initial values, execution from zero
			s_nxt.st = ST_RESET;
			s_nxt.se = 1'b0;
			s_nxt.sm = 1'b0;
			s_nxt.core_rst = 1'b1;
			s_nxt.core_halt = 1'b0;
			s_nxt.osc_en = 1'b1;
			s_nxt.pdown = 1'b0;
			s_nxt.cnt = 17'h00000;
		end else begin
			case (s_r.st)
				ST_RESET: begin
					// Wait for the release of every source, then time out
					if (!rst_low_now && !s_r.wdt_q) begin
						s_nxt.cnt = rt_part(s_r.clock_select_code);
						s_nxt.st = (rt_part(s_r.clock_select_code) == 17'h00000) ? ST_CK : ST_RT;
						if (rt_part(s_r.clock_select_code) == 17'h00000)
							s_nxt.cnt = ck_part(s_r.clock_select_code);
					end
				end
				ST_RT: begin
					if (wd_tick) begin
						s_nxt.cnt = s_r.cnt - 17'h00001;
						if (s_r.cnt == 17'h00001) begin
							s_nxt.cnt = ck_part(s_r.clock_select_code);
							s_nxt.st = ST_CK;
						end
					end
				end
				ST_CK: begin
					s_nxt.cnt = s_r.cnt - 17'h00001;
					if (s_r.pdown && wd_tick && s_r.wd_seen != 2'h3)
						s_nxt.wd_seen = s_r.wd_seen + 2'h1;
					if (s_r.pdown && !lvl_active)
						s_nxt.lvl_ok = 1'b0;
					if (s_r.cnt == 17'h00001) begin
						s_nxt.st = ST_RUN;
						s_nxt.core_rst = 1'b0;
						if (s_r.pdown) begin
							// Held two watchdog ticks, or the whole shorter period
							s_nxt.core_halt = 1'b1;
							s_nxt.hold = 3'(`SRS_WAKE_HOLD_CYC);
							s_nxt.st = ST_WAKE;
							s_nxt.irq_wake = s_r.lvl_ok && lvl_active;
							s_nxt.pdown = 1'b0;
						end
					end
					if (s_r.pdown && s_r.lvl_ok && lvl_active
						&& s_r.wd_seen >= 2'(`SRS_LEVEL_WD_CYC)) begin
						s_nxt.irq_wake = 1'b1;
						s_nxt.core_halt = 1'b1;
						s_nxt.hold = 3'(`SRS_WAKE_HOLD_CYC);
						s_nxt.st = ST_WAKE;
						s_nxt.pdown = 1'b0;
					end
				end
				ST_RUN: begin
					if (sleep_instr && s_r.se) begin
						s_nxt.st = ST_SLEEP;
						s_nxt.core_halt = 1'b1;
						s_nxt.osc_en = !s_r.sm;
						s_nxt.pdown = s_r.sm;
					end
				end
				ST_SLEEP: begin
					if (s_r.pdown) begin
						// Only a level wake, or a reset above, ends power-down
						if (lvl_active) begin
							s_nxt.osc_en = 1'b1;
							s_nxt.cnt = ck_part(s_r.clock_select_code);
							s_nxt.wd_seen = 2'h0;
							s_nxt.lvl_ok = 1'b1;
							s_nxt.st = ST_CK;
						end
					end else if (irq_pending) begin
						s_nxt.hold = 3'(`SRS_WAKE_HOLD_CYC);
						s_nxt.irq_wake = 1'b1;
						s_nxt.st = ST_WAKE;
					end
				end
				ST_WAKE: begin
					s_nxt.hold = s_r.hold - 3'h1;
					if (s_r.hold == 3'h1) begin
						s_nxt.core_halt = 1'b0;
						s_nxt.st = ST_RUN;
					end
				end
				default: s_nxt.st = ST_RESET;
			endcase
		end
		if (wdt_fall)
			s_nxt.st = ST_RESET;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.st <= ST_RESET;
			s_r.rst_s <= 3'h7;
			s_r.lvl_s <= 3'h7;
			s_r.powerup_reset_flag <= 1'b1;
			s_r.clock_select_code <= `SRS_CLOCK_SELECT_CODE_RESET;
			s_r.core_rst <= 1'b1;
			s_r.osc_en <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign axi_rsp = s_r.axi;
	assign core_reset = s_r.core_rst;
	assign core_halt = s_r.core_halt;
	assign osc_enable = s_r.osc_en;
	assign wake_irq = s_r.irq_wake;

	logic powerup_reset_flag_chk;
	assign powerup_reset_flag_chk = s_r.powerup_reset_flag;

	chk_sleep_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == ST_RUN && sleep_instr && !s_r.se && !any_rst && !wdt_fall)
		|=> s_r.st == ST_RUN)
		else $error("Sleep entered without enable");
	chk_pdown_osc_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == ST_SLEEP && s_r.pdown) |-> !osc_enable)
		else $error("Oscillator running in power-down");
	chk_wake_hold_four: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st != ST_WAKE ##1 s_r.st == ST_WAKE) |-> core_halt [*4] ##1 !core_halt)
		else $error("Wake hold not four cycles");
	chk_supply_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		!supply_ok |=> core_reset && powerup_reset_flag_chk)
		else $error("Supply loss did not reset");
	chk_idle_osc_on: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == ST_SLEEP && !s_r.pdown) |-> osc_enable)
		else $error("Idle stopped the oscillator");
	chk_reset_held: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == ST_RESET || s_r.st == ST_RT) |-> core_reset)
		else $error("Core released during time-out");
	chk_reset_vector: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == ST_SLEEP && !supply_ok) |=> s_r.st == ST_RESET && core_reset)
		else $error("Reset in sleep did not restart");
	chk_pdown_ck_only: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_r.st == ST_SLEEP && s_r.pdown && lvl_active && !any_rst && !wdt_fall)
		|=> s_r.st == ST_CK)
		else $error("Power-down wake used real-time part");
endmodule

// file: bench/srs_far_model.sv
// Far-side model: core that issues the sleep instruction, watchdog oscillator.
// Assumes one aclk domain; the bench asks for a sleep through sleep_req.
`timescale 1ns/1ps
module srs_far_model (
	// Clock
	input wire logic aclk,
	// Core status and bench request
	input wire logic core_reset,
	input wire logic core_halt,
	input wire logic sleep_req,
	// Core and oscillator outputs
	output logic sleep_instr,
	output logic wd_osc
);
	logic [1:0] div_r = 2'h0;
	logic slp_r = 1'b0;
	always_ff @(posedge aclk) begin
		div_r <= div_r + 2'h1;
		// Core runs the sleep instruction only while running
		slp_r <= sleep_req & ~core_reset & ~core_halt;
	end
	// Free-running oscillator, period four clocks
	assign wd_osc = div_r[1];
	assign sleep_instr = slp_r;
endmodule

// file: bench/tb_sleep_reset_startup_sequencer.sv
// Self-checking bench for the sleep, reset and start-up sequencer.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "srs_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin $display("CHECK FAILED %s exp %0h got %0h", n, e, g); miscompares++; end end
module tb_sleep_reset_startup_sequencer;
	import srs_pkg::*;
	logic aclk, aresetn, supply_ok, reset_pin_n, wd_timeout, irq_pending, level_wake_n, sleep_req;
	logic wd_osc, sleep_instr, core_reset, core_halt, osc_enable, wake_irq;
	srs_axi_req_type req;
	srs_axi_rsp_type rsp;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [31:0] rnd;
	int miscompares = 0, cmp_count = 0, wake_cnt = 0, cyc = 0, n, t0, w0;

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	srs_sequencer i_srs_sequencer (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.supply_ok(supply_ok), .reset_pin_n(reset_pin_n), .wd_osc(wd_osc),
		.wd_timeout(wd_timeout), .sleep_instr(sleep_instr), .irq_pending(irq_pending),
		.level_wake_n(level_wake_n), .core_reset(core_reset), .core_halt(core_halt),
		.osc_enable(osc_enable), .wake_irq(wake_irq));
	srs_far_model i_srs_far_model (.aclk(aclk), .core_reset(core_reset), .core_halt(core_halt),
		.sleep_req(sleep_req), .sleep_instr(sleep_instr), .wd_osc(wd_osc));

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic ticks(input int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, d});
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
	endtask

	task automatic go_sleep;
		@(posedge aclk);
		sleep_req <= 1'b1;
		@(posedge aclk);
		sleep_req <= 1'b0;
		ticks(3);
	endtask

	task automatic wait_clear(input bit use_rst);
		n = 0;
		while ((use_rst ? core_reset : core_halt) !== 1'b0) begin
			@(posedge aclk);
			n++;
		end
	endtask

	// Response checker and hang guard
	always @(posedge aclk) begin
		cyc++;
		if (wake_irq === 1'b1) wake_cnt++;
		if ((rsp.rvalid & req.rready) === 1'b1 || (rsp.bvalid & req.bready) === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
			if (rsp.bvalid === 1'b1) begin
				`CHK("bresp", e[33:32], rsp.bresp)
			end else begin
				`CHK("rresp", e[33:32], rsp.rresp)
				if (e[33:32] == `SRS_RESP_OKAY) `CHK("rdata", e[31:0], rsp.rdata)
			end
		end
		if (cyc == 90000) begin
			miscompares++;
			complete_run;
		end
	end

	initial begin
		aresetn = 1'b0;
		supply_ok = 1'b1;
		reset_pin_n = 1'b1;
		wd_timeout = 1'b0;
		irq_pending = 1'b0;
		level_wake_n = 1'b1;
		sleep_req = 1'b0;
		req = '0;
		rnd = $urandom(51284);
		ticks(12);
		aresetn <= 1'b1;
		t0 = cyc;
		rd(`SRS_REG_CTRL, 32'h1, `SRS_RESP_OKAY);
		rd(`SRS_REG_CFG, 32'h2, `SRS_RESP_OKAY);
		rd(32'hc, 32'h0, `SRS_RESP_SLVERR);
		wr(32'h10, 32'h0, `SRS_RESP_SLVERR);
		wait_clear(1'b1);
		`CHK("startup_len", 1'b1, (cyc - t0 >= 65532 && cyc - t0 <= 65600))
		rnd = $urandom;
		wr(`SRS_REG_CFG, {rnd[31:4], 4'h4}, `SRS_RESP_OKAY);
		rd(`SRS_REG_CFG, 32'h4, `SRS_RESP_OKAY);
		wr(`SRS_REG_CTRL, 32'h0, `SRS_RESP_OKAY);
		go_sleep;
		`CHK("halt_no_enable", 1'b0, core_halt)
		wr(`SRS_REG_CTRL, 32'h20, `SRS_RESP_OKAY);
		go_sleep;
		`CHK("idle_halt", 1'b1, core_halt)
		`CHK("idle_osc", 1'b1, osc_enable)
		ticks(1 + rnd[6:4]);
		w0 = wake_cnt;
		irq_pending <= 1'b1;
		wait_clear(1'b0);
		irq_pending <= 1'b0;
		`CHK("idle_wake", w0 + 1, wake_cnt)
		`CHK("idle_hold", 1'b1, (n >= 5 && n <= 10))
		`CHK("idle_no_rst", 1'b0, core_reset)
		wr(`SRS_REG_CTRL, 32'h30, `SRS_RESP_OKAY);
		go_sleep;
		`CHK("pd_osc_off", 1'b0, osc_enable)
		irq_pending <= 1'b1;
		ticks(6);
		irq_pending <= 1'b0;
		`CHK("pd_irq_ignored", 1'b1, core_halt)
		w0 = wake_cnt;
		level_wake_n <= 1'b0;
		ticks(3);
		level_wake_n <= 1'b1;
		wait_clear(1'b0);
		`CHK("pd_short_level", w0, wake_cnt)
		`CHK("pd_osc_on", 1'b1, osc_enable)
		go_sleep;
		level_wake_n <= 1'b0;
		wait_clear(1'b0);
		level_wake_n <= 1'b1;
		`CHK("pd_level_wake", w0 + 1, wake_cnt)
		`CHK("pd_wake_len", 1'b1, (n <= 30))
		wr(`SRS_REG_CTRL, 32'h20, `SRS_RESP_OKAY);
		go_sleep;
		reset_pin_n <= 1'b0;
		ticks(8);
		reset_pin_n <= 1'b1;
		`CHK("pin_reset", 1'b1, core_reset)
		wait_clear(1'b1);
		`CHK("pin_timeout", 1'b1, (n >= 6 && n <= 30))
		`CHK("pin_not_halted", 1'b0, core_halt)
		rd(`SRS_REG_CTRL, 32'h2, `SRS_RESP_OKAY);
		// Held long enough for the synchroniser stages to agree
		wd_timeout <= 1'b1;
		ticks(3);
		wd_timeout <= 1'b0;
		ticks(3);
		`CHK("wd_reset", 1'b1, core_reset)
		wait_clear(1'b1);
		`CHK("wd_timeout_len", 1'b1, (n >= 6 && n <= 30))
		rd(`SRS_REG_CTRL, 32'ha, `SRS_RESP_OKAY);
		supply_ok <= 1'b0;
		ticks(2);
		`CHK("supply_reset", 1'b1, core_reset)
		rd(`SRS_REG_CTRL, 32'h1, `SRS_RESP_OKAY);
		supply_ok <= 1'b1;
		ticks(4);
		complete_run;
	end
endmodule
